// ==== rtl/ipag_adder.sv ====
// 23-bit wrapping pointer adder; the offset arrives already extended to 23 bits
`timescale 1ns/1ps
`include "ipag_defines.svh"
module ipag_adder
	import ipag_pkg::*;
(
	input  wire logic [`IPAG_ADDR_W-1:0] base,     // pointer value
	input  wire logic [`IPAG_ADDR_W-1:0] offset,   // already extended offset
	input  wire logic                    subtract, // subtract instead of add
	output logic      [`IPAG_ADDR_W-1:0] result    // wrapped result
);
	// --------------------------------
	// wrap arithmetic
	// --------------------------------
	// carry or borrow past bit 22 is dropped by the fixed width
	always_comb begin
		if (subtract) begin
			result = base - offset;
		end else begin
			result = base + offset;
		end
	end
endmodule // ipag_adder

// ==== rtl/ipag_addr_gen.sv ====
// indirect pointer address generator top
// --------------------------------
// --------------------------------
// --------------------------------
// Request timing
// --------------------------------
// edge 0: req, op, size, space and operands sampled together
// edge 1: ack or err rises for one cycle; addr, ptr_new, ptr_we with ack
// edge 2: pulses drop; addr and ptr_new hold until the next accepted op
// a request may follow every cycle; the pointer file outside must forward
// ptr_new while ptr_we is high, or the next op reads a stale pointer
// a refused op keeps addr and ptr_new, so a late write-back stays harmless
// --------------------------------
// Limitations
// --------------------------------
// bit-reverse, circular and dual-pointer operands are not decoded; their
// codes are left unused and answer with err
// every input comes from logic on clk_sys, so none is resynchronised
// one request at a time: the output registers and the st_r state register are the only storage
`timescale 1ns/1ps
`include "ipag_defines.svh"
module ipag_addr_gen
	import ipag_pkg::*;
(
	input  wire logic                    clk_sys,          // cpu clock
	input  wire logic                    rst,              // async reset, high
	input  wire logic                    req,              // one-cycle request
	input  wire logic [2:0]              op,               // ipag_op_e code
	input  wire logic [1:0]              space,            // ipag_space_e code
	input  wire logic                    wide,             // double word or bit pair
	input  wire logic                    parallel,         // paired with other insn
	input  wire logic                    addr_mode_select, // 0 dsp, 1 control
	input  wire logic                    legacy_compat_bit,// index source select
	input  wire logic [`IPAG_ADDR_W-1:0] extended_aux_pointer_n,    // pointer in
	input  wire logic [`IPAG_ADDR_W-1:0] extended_aux_pointer_zero, // alt index
	input  wire logic [`IPAG_IDX_W-1:0]  temp_index_zero,  // 16-bit index
	input  wire logic [`IPAG_IDX_W-1:0]  imm16_offset,     // 16-bit immediate
	output logic                         ack,              // result valid pulse
	output logic                         err,              // refused request pulse
	output logic      [`IPAG_ADDR_W-1:0] addr,             // operand address
	output logic      [`IPAG_ADDR_W-1:0] ptr_new,          // updated pointer
	output logic                         ptr_we            // write pointer back
);
	// --------------------------------
	// helpers
	// --------------------------------
	function automatic logic [`IPAG_ADDR_W-1:0] sext16(input logic [`IPAG_IDX_W-1:0] v);
		sext16 = {{(`IPAG_ADDR_W-`IPAG_IDX_W){v[`IPAG_IDX_W-1]}}, v};
	endfunction

	// index for the post-add form: sign-extended temp index, or the full
	// 23-bit alternate pointer when the legacy bit is set
	function automatic logic [`IPAG_ADDR_W-1:0] idx_pick(
		input logic                    compat, // legacy compat bit
		input logic [`IPAG_IDX_W-1:0]  t_idx,  // 16-bit index
		input logic [`IPAG_ADDR_W-1:0] p_idx   // 23-bit alternate pointer
	);
		if (compat == `IPAG_CMPT_NEW) begin
			idx_pick = sext16(t_idx);
		end else begin
			idx_pick = p_idx;
		end
	endfunction

	// operand set of each mode; both sets hold every form decoded here, so
	// the mode bit only matters once mode-only forms are added
	function automatic logic in_op_set(input logic mode, input ipag_op_e o);
		in_op_set = 1'b0;
		if (mode == `IPAG_MODE_DSP) begin
			case (o)
				IPAG_OP_PLAIN, IPAG_OP_POSTINC:   in_op_set = 1'b1;
				IPAG_OP_POSTDEC, IPAG_OP_POSTIDX: in_op_set = 1'b1;
				IPAG_OP_PREIMM:                   in_op_set = 1'b1;
				default:                          in_op_set = 1'b0;
			endcase
		end else begin
			// control set: post-decrement is listed here explicitly
			case (o)
				IPAG_OP_PLAIN, IPAG_OP_POSTINC:   in_op_set = 1'b1;
				IPAG_OP_POSTDEC, IPAG_OP_POSTIDX: in_op_set = 1'b1;
				IPAG_OP_PREIMM:                   in_op_set = 1'b1;
				default:                          in_op_set = 1'b0;
			endcase
		end
	endfunction

	// --------------------------------
	// operand decode
	// --------------------------------
	logic [`IPAG_ADDR_W-1:0] step;
	logic [`IPAG_ADDR_W-1:0] offset;
	logic                    sub;
	logic [`IPAG_ADDR_W-1:0] sum;
	logic                    legal;
	logic                    modify;
	logic                    pre;
	ipag_op_e                op_c;

	// step, offset and legality per operand kind
	always_comb begin
		op_c   = ipag_op_e'(op);
		// bit access sizes map the same as word sizes
		step   = wide ? `IPAG_STEP_TWO : `IPAG_STEP_ONE;
		offset = step;
		sub    = 1'b0;
		modify = 1'b1;
		pre    = 1'b0;
		legal  = 1'b1;
		case (op_c)
			IPAG_OP_PLAIN: begin
				modify = 1'b0; // pointer untouched, every space
			end
			IPAG_OP_POSTINC: begin
				offset = step;
			end
			IPAG_OP_POSTDEC: begin
				sub = 1'b1;
			end
			IPAG_OP_POSTIDX: begin
				// index source by compat bit, added after the address
				offset = idx_pick(legacy_compat_bit, temp_index_zero,
					extended_aux_pointer_zero);
			end
			IPAG_OP_PREIMM: begin
				offset = sext16(imm16_offset);
				pre    = 1'b1;
				// no io space, no parallel issue
				legal  = (ipag_space_e'(space) != IPAG_SP_IO) && !parallel;
			end
			default: begin
				legal  = 1'b0;
			end
		endcase
		// a form outside the selected mode's set is refused like a bad code
		if (!in_op_set(addr_mode_select, op_c)) begin
			legal = 1'b0;
		end
	end

	// one shared adder serves every form; it subtracts only for post-decrement
	ipag_adder u_add (
		.base     (extended_aux_pointer_n),
		.offset   (offset),
		.subtract (sub),
		.result   (sum)
	);

	// --------------------------------
	// output registers
	// --------------------------------
	ipag_state_e             st_r,   st_nxt;
	logic                    ack_r,  ack_nxt;
	logic                    err_r,  err_nxt;
	logic                    we_r,   we_nxt;
	logic [`IPAG_ADDR_W-1:0] addr_r, addr_nxt;
	logic [`IPAG_ADDR_W-1:0] ptr_r,  ptr_nxt;

	// address before or after modification, one cycle latency
	always_comb begin
		st_nxt   = IPAG_ST_IDLE;
		ack_nxt  = 1'b0;
		err_nxt  = 1'b0;
		we_nxt   = 1'b0;
		addr_nxt = addr_r;
		ptr_nxt  = ptr_r;
		case (st_r)
			IPAG_ST_IDLE, IPAG_ST_DONE: begin
				if (req && legal) begin
					st_nxt   = IPAG_ST_DONE;
					ack_nxt  = 1'b1;
					// pre form uses the updated pointer as address
					addr_nxt = pre ? sum : extended_aux_pointer_n;
					ptr_nxt  = modify ? sum : extended_aux_pointer_n;
					we_nxt   = modify;
				end else if (req) begin
					err_nxt  = 1'b1; // refused, pointer kept
				end
			end
			default: begin
				st_nxt = IPAG_ST_IDLE;
			end
		endcase
	end

	// registers only; reset clears every pulse so no stray write-back leaves
	// while the cpu is held
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r   <= IPAG_ST_IDLE;
			ack_r  <= 1'b0;
			err_r  <= 1'b0;
			we_r   <= 1'b0;
			addr_r <= `IPAG_PTR_RST;
			ptr_r  <= `IPAG_PTR_RST;
		end else begin
			st_r   <= st_nxt;
			ack_r  <= ack_nxt;
			err_r  <= err_nxt;
			we_r   <= we_nxt;
			addr_r <= addr_nxt;
			ptr_r  <= ptr_nxt;
		end
	end

	// outputs come straight from the registers
	assign ack     = ack_r;
	assign err     = err_r;
	assign addr    = addr_r;
	assign ptr_new = ptr_r;
	assign ptr_we  = we_r;
endmodule // ipag_addr_gen

// ==== rtl/ipag_defines.svh ====
// constants for the indirect pointer address generator
`ifndef IPAG_DEFINES_SVH
`define IPAG_DEFINES_SVH
`define IPAG_ADDR_W     23
`define IPAG_IDX_W      16
`define IPAG_STEP_ONE   23'h00_0001
`define IPAG_STEP_TWO   23'h00_0002
`define IPAG_PTR_RST    23'h00_0000
`define IPAG_MODE_DSP   1'b0
`define IPAG_CMPT_NEW   1'b0
`endif

// ==== rtl/ipag_pkg.sv ====
// types for the indirect pointer address generator
package ipag_pkg;
	// pointer modification kinds
	typedef enum logic [2:0] {
		IPAG_OP_PLAIN  = 3'h0,
		IPAG_OP_POSTINC = 3'h1,
		IPAG_OP_POSTDEC = 3'h2,
		IPAG_OP_POSTIDX = 3'h3,
		IPAG_OP_PREIMM  = 3'h4
	} ipag_op_e;
	// access space
	typedef enum logic [1:0] {
		IPAG_SP_DATA = 2'h0,
		IPAG_SP_MMR  = 2'h1,
		IPAG_SP_RBIT = 2'h2,
		IPAG_SP_IO   = 2'h3
	} ipag_space_e;
	// handshake states, one-hot
	typedef enum logic [1:0] {
		IPAG_ST_IDLE = 2'b01,
		IPAG_ST_DONE = 2'b10
	} ipag_state_e;
endpackage

// ==== verif/ipag_addr_gen_sva.sv ====
// checker for the address generator ports
`timescale 1ns/1ps
`include "ipag_defines.svh"
module ipag_addr_gen_chk (
	input wire logic        clk_sys,                   // clock
	input wire logic        rst,                       // reset
	input wire logic        req,                       // request
	input wire logic [2:0]  op,                        // op code
	input wire logic [1:0]  space,                     // space
	input wire logic        wide,                      // step 2
	input wire logic        parallel,                  // paired
	input wire logic        legacy_compat_bit,         // index pick
	input wire logic [22:0] extended_aux_pointer_n,    // pointer
	input wire logic [22:0] extended_aux_pointer_zero, // alt index
	input wire logic [15:0] temp_index_zero,           // index
	input wire logic [15:0] imm16_offset,              // immediate
	input wire logic        ack,                       // done
	input wire logic        err,                       // refused
	input wire logic [22:0] addr,                      // address
	input wire logic [22:0] ptr_new,                   // new pointer
	input wire logic        ptr_we                     // write back
);
	// extended operands; 23-bit sums wrap on their own
	wire [22:0] p = extended_aux_pointer_n;
	wire [22:0] st = wide ? `IPAG_STEP_TWO : `IPAG_STEP_ONE;
	wire [22:0] ix = legacy_compat_bit ? extended_aux_pointer_zero :
		{{7{temp_index_zero[15]}}, temp_index_zero};
	wire [22:0] im = {{7{imm16_offset[15]}}, imm16_offset};
	wire        bad = op > 3'h4 || op == 3'h4 && (space == 2'h3 || parallel);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	refuse_op_a: assert property (req && bad |=>
		err && !ack && $stable(addr) && $stable(ptr_new)) else $error("refusal wrong");
	take_op_a: assert property (req && !bad |=> ack && !err) else $error("no ack");
	plain_keep_a: assert property (req && op == 3'h0 |=>
		!ptr_we && addr == $past(p) && ptr_new == $past(p)) else $error("plain wrong");
	post_inc_a: assert property (req && op == 3'h1 |=>
		ptr_we && addr == $past(p) && ptr_new == $past(p) + $past(st)) else $error("inc");
	post_dec_a: assert property (req && op == 3'h2 |=>
		ptr_we && addr == $past(p) && ptr_new == $past(p) - $past(st)) else $error("dec");
	post_idx_a: assert property (req && op == 3'h3 |=>
		addr == $past(p) && ptr_new == $past(p) + $past(ix)) else $error("index");
	pre_imm_a: assert property (req && op == 3'h4 && !bad |=>
		addr == ptr_new && ptr_new == $past(p) + $past(im)) else $error("imm");
	we_with_ack_a: assert property (ptr_we |-> ack) else $error("stray write");
endmodule // ipag_addr_gen_chk

// ==== verif/ipag_ptr_mdl.sv ====
// pointer register file standing in for the cpu side
`timescale 1ns/1ps
module ipag_ptr_mdl (
	input  wire logic        clk_sys, // clock
	input  wire logic        rst,     // reset
	input  wire logic        ld,      // bench load
	input  wire logic [22:0] ld_val,  // load value
	input  wire logic        ptr_we,  // write back
	input  wire logic [22:0] ptr_new, // written value
	output logic      [22:0] ptr      // pointer out
);
	logic [22:0] ptr_r;
	// forwarding so back-to-back ops see the fresh pointer
	assign ptr = ptr_we ? ptr_new : ptr_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) ptr_r <= 23'h00_0000;
		else if (ld) ptr_r <= ld_val;
		else if (ptr_we) ptr_r <= ptr_new;
	end
endmodule // ipag_ptr_mdl

// ==== verif/test_ipag_addr_gen.sv ====
// bench for the address generator
`timescale 1ns/1ps
module test_ipag_addr_gen;
	logic clk_sys = 0, rst = 1, req = 0, wide = 0, parallel = 0, ld = 0, ack, err, ptr_we;
	logic addr_mode_select = 0, legacy_compat_bit = 0;
	logic [2:0] op = '0;
	logic [1:0] space = '0;
	logic [15:0] temp_index_zero = '0, imm16_offset = '0;
	logic [22:0] extended_aux_pointer_zero = '0, lv = '0, extended_aux_pointer_n, addr, ptr_new;
	int err_count = 0, checks_done = 0, cyc = 0;
	always #25 clk_sys = ~clk_sys;
	ipag_addr_gen u_ipag_addr_gen (.clk_sys, .rst, .req, .op, .space, .wide, .parallel,
		.addr_mode_select, .legacy_compat_bit, .extended_aux_pointer_n, .ack, .err,
		.extended_aux_pointer_zero, .temp_index_zero, .imm16_offset, .addr, .ptr_new, .ptr_we);
	ipag_ptr_mdl u_ipag_ptr_mdl (.clk_sys, .rst, .ld, .ld_val(lv), .ptr_we, .ptr_new,
		.ptr(extended_aux_pointer_n));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [22:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one request; answer is judged one cycle later
	task automatic go(input logic [2:0] o, input logic w, input logic [22:0] ea, ep,
		input logic ew, ok);
		op = o;
		wide = w;
		req = 1;
		@(negedge clk_sys);
		chk(ack, ok);
		chk(err, !ok);
		chk(addr, ea);
		chk(ptr_new, ep);
		chk(ptr_we, ew);
	endtask
	task automatic setp(input logic [22:0] v);
		req = 0;
		ld = 1;
		lv = v;
		@(negedge clk_sys);
		ld = 0;
	endtask
	task automatic t_step;
		for (int m = 0; m < 2; m++) for (int w = 0; w < 2; w++) begin
			addr_mode_select = m[0];
			space = 2'h2;
			setp(23'h7f_ffff);
			go(3'h1, w[0], 23'h7f_ffff, {22'h0, w[0]}, 1, 1);
			go(3'h2, w[0], {22'h0, w[0]}, 23'h7f_ffff, 1, 1);
		end
		setp(23'h12_3456);
		space = 2'h3;
		go(3'h0, 0, 23'h12_3456, 23'h12_3456, 0, 1);
		$display("step tests done");
	endtask
	task automatic t_mod;
		setp(23'h00_0010);
		space = 2'h0;
		temp_index_zero = 16'h8000;
		extended_aux_pointer_zero = 23'h40_0000;
		go(3'h3, 0, 23'h00_0010, 23'h7f_8010, 1, 1);
		legacy_compat_bit = 1;
		go(3'h3, 0, 23'h7f_8010, 23'h3f_8010, 1, 1);
		setp(23'h00_0005);
		imm16_offset = 16'hfffe;
		space = 2'h1;
		go(3'h4, 0, 23'h00_0003, 23'h00_0003, 1, 1);
		space = 2'h3;
		go(3'h4, 0, 23'h00_0003, 23'h00_0003, 0, 0);
		space = 2'h2;
		parallel = 1;
		go(3'h4, 0, 23'h00_0003, 23'h00_0003, 0, 0);
		for (int o = 5; o < 8; o++) go(o[2:0], 0, 23'h00_0003, 23'h00_0003, 0, 0);
		$display("modify tests done");
	endtask
	// hang guard well above the run length
	always @(posedge clk_sys) if (++cyc == 500) begin
		err_count++;
		end_sim;
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 0;
		t_step;
		t_mod;
		end_sim;
	end
endmodule // test_ipag_addr_gen
bind ipag_addr_gen ipag_addr_gen_chk u_ipag_addr_gen_chk (.*);
